// ===== verilog/fmtc_pkg.sv
// Package with register map, field positions and constants of the format track command block.
`default_nettype none
package fmtc_pkg;
   localparam logic [11:0] FMTC_OFF_DATA = 12'h000;
   localparam logic [11:0] FMTC_OFF_MSR = 12'h004;
   localparam logic [11:0] FMTC_OFF_DOR = 12'h008;
   localparam logic [11:0] FMTC_OFF_SRA = 12'h00c;
   localparam logic [11:0] FMTC_OFF_MODE = 12'h010;
   localparam logic [11:0] FMTC_OFF_ST3 = 12'h014;
   localparam logic [11:0] FMTC_OFF_STAT = 12'h018;
   localparam logic [4:0] FMTC_OPC_FORMAT = 5'h0d;
   localparam int FMTC_OPC_DD_BIT = 6;
   localparam logic [7:0] FMTC_ST0_INVALID = 8'h80;
   localparam int FMTC_MSR_RQM = 7;
   localparam int FMTC_MSR_DIO = 6;
   localparam int FMTC_MSR_BUSY = 4;
   localparam int FMTC_SRA_SIDE = 3;
   localparam int FMTC_ST_SIDE = 2;
   localparam int FMTC_MODE_IAF = 6;
   localparam int FMTC_MODE_FOUR = 0;
   localparam int FMTC_MODE_SWAP = 1;
   localparam logic [2:0] FMTC_PARAM_CNT = 3'h5;
   localparam logic [2:0] FMTC_RES_CNT = 3'h7;
   localparam logic [1:0] FMTC_ID_CNT = 2'h3;
   localparam logic [7:0] FMTC_BASE_LEN = 8'h80;
   localparam logic [7:0] FMTC_INDEX_FIELD_LEN = 8'h04;
   typedef enum logic [2:0] {
      FMTC_IDLE, FMTC_PARAM, FMTC_WAIT_IDX, FMTC_ID, FMTC_DATA, FMTC_GAP, FMTC_FILL, FMTC_RESULT
   } fmtc_state_e;
endpackage
`default_nettype wire

// ===== verilog/fmtc_apb.sv
// APB slave front end that turns bus transfers into one-cycle register strobes.
`timescale 1ns/100ps
`default_nettype none
module fmtc_apb (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [7:0] rd_data,
   input wire logic known,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic wr_stb,
   output logic rd_stb,
   output logic [7:0] wr_data
);
   typedef struct packed {
      logic [31:0] prdata;
   } fmtc_apb_s;
   fmtc_apb_s r;
   fmtc_apb_s next_r;
   logic access;
   assign access = psel && penable;
   assign pready = access;
   assign pslverr = access && !known;
   assign wr_stb = access && pwrite && known;
   assign rd_stb = access && !pwrite && known;
   assign wr_data = pwdata[7:0];
   assign prdata = r.prdata;
   always_comb begin
      next_r = r;
      if (psel && !penable && !pwrite) begin
         next_r.prdata = {24'h000000, rd_data};
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/fmtc_len.sv
// Data field length counter loaded from the sector size code.
`timescale 1ns/100ps
`default_nettype none
module fmtc_len (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic step,
   input wire logic [2:0] size_code,
   output logic done
);
   typedef struct packed {
      logic [14:0] left;
   } fmtc_len_s;
   fmtc_len_s r;
   fmtc_len_s next_r;
   assign done = (r.left == 15'h0000);
   always_comb begin
      next_r = r;
      if (load) begin
         next_r.left = 15'((15'h0080 << size_code) - 15'h0001);
      end else if (step && !done) begin
         next_r.left = r.left - 15'h0001;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/fmtc_top.sv
// Format track command interpreter with APB registers and a byte-wide write path to the drive.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
//Contract
//- Drive code maps per drive count and swap.
//- Drive select mirrors output register and status.
//- Side bit drives inverted head output.
//- Side shown in status registers bits.
//- Data length is 128 shifted by code.
//- Fourth byte sets sector count.
//- Fifth byte sets gap three length.
//- Data field filled with pattern byte.
//- Whole track written by one command.
//- Seven result bytes, last four undefined.
//- Illegal opcode skips to result phase.
//- Illegal opcode raises no interrupt.
//- Illegal opcode sets status bit seven, clears six.
//- Illegal opcode status byte reads 80h.
//- Format spans index to next index.
//- Opcode bit six selects density.
//- Index field written unless omitted.
module fmtc_top (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic [31:0] PRDATA,
   input wire logic INDEX_B,
   output logic HEAD_SIDE_OUTPUT_B,
   output logic [1:0] DRIVE_SEL,
   output logic DOUBLE_DENSITY,
   output logic WR_GATE,
   output logic [7:0] WR_BYTE,
   output logic WR_BYTE_VLD,
   output logic INDEX_FIELD_WR,
   output logic IRQ
);
   import fmtc_pkg::*;
   typedef struct packed {
      fmtc_state_e state;
      logic [1:0] idx_sync;
      logic idx_prev;
      logic [2:0] pcnt;
      logic [1:0] idcnt;
      logic [7:0] secs_left;
      logic [7:0] gap_left;
      logic [2:0] rcnt;
      logic [2:0] rlen;
      logic [7:0] st0;
      logic [7:0] st1;
      logic [7:0] st2;
      logic [1:0] drive;
      logic side;
      logic dd;
      logic [2:0] size;
      logic [7:0] secs;
      logic [7:0] gap3;
      logic [7:0] fill;
      logic [7:0] mode;
      logic [7:0] wbyte;
      logic wvld;
      logic idxf;
      logic idreq;
      logic irq;
      logic bad_drive;
   } fmtc_top_s;
   fmtc_top_s r;
   fmtc_top_s next_r;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic known;
   logic [31:0] prdata_i;
   logic len_load;
   logic len_step;
   logic len_done;
   logic idx_edge;
   logic data_wr;
   logic data_rd;
   logic [7:0] main_status_register;
   logic [7:0] res_byte;
   logic [7:0] st3;
   fmtc_apb u_apb (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .psel(PSEL),
      .penable(PENABLE),
      .pwrite(PWRITE),
      .paddr(PADDR),
      .pwdata(PWDATA),
      .rd_data(rd_data),
      .known(known),
      .pready(PREADY),
      .pslverr(PSLVERR),
      .prdata(prdata_i),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .wr_data(wr_data)
   );
   fmtc_len u_len (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .load(len_load),
      .step(len_step),
      .size_code(r.size),
      .done(len_done)
   );
   assign PRDATA = prdata_i;
   assign idx_edge = r.idx_sync[1] && !r.idx_prev;
   assign data_wr = wr_stb && (PADDR == FMTC_OFF_DATA);
   assign data_rd = rd_stb && (PADDR == FMTC_OFF_DATA);
   assign len_load = (r.state == FMTC_ID) && data_wr && (r.idcnt == FMTC_ID_CNT);
   assign len_step = (r.state == FMTC_DATA);
   assign known = (PADDR == FMTC_OFF_DATA) || (PADDR == FMTC_OFF_MSR) ||
      (PADDR == FMTC_OFF_DOR) || (PADDR == FMTC_OFF_SRA) || (PADDR == FMTC_OFF_MODE) ||
      (PADDR == FMTC_OFF_ST3) || (PADDR == FMTC_OFF_STAT);
   always_comb begin
      main_status_register = 8'h00;
      case (r.state)
         FMTC_IDLE, FMTC_PARAM: main_status_register[FMTC_MSR_RQM] = 1'b1;
         FMTC_RESULT: begin
            main_status_register[FMTC_MSR_RQM] = 1'b1;
            main_status_register[FMTC_MSR_DIO] = 1'b1;
         end
         FMTC_ID: main_status_register[FMTC_MSR_RQM] = r.idreq;
         default: main_status_register = 8'h00;
      endcase
      if (r.state != FMTC_IDLE) begin
         main_status_register[FMTC_MSR_BUSY] = 1'b1;
      end
   end
   always_comb begin
      case (r.rcnt)
         3'h0: res_byte = r.st0;
         3'h1: res_byte = r.st1;
         3'h2: res_byte = r.st2;
         default: res_byte = 8'h00;
      endcase
   end
   assign st3 = {5'h00, r.side, r.drive};
   always_comb begin
      rd_data = 8'h00;
      case (PADDR)
         FMTC_OFF_DATA: rd_data = (r.state == FMTC_RESULT) ? res_byte : 8'h00;
         FMTC_OFF_MSR: rd_data = main_status_register;
         FMTC_OFF_DOR: rd_data = {6'h00, r.drive};
         FMTC_OFF_SRA: rd_data = {4'h0, r.side, 3'h0};
         FMTC_OFF_MODE: rd_data = r.mode;
         FMTC_OFF_ST3: rd_data = st3;
         FMTC_OFF_STAT: rd_data = {7'h00, r.irq};
         default: rd_data = 8'h00;
      endcase
   end
   always_comb begin
      next_r = r;
      next_r.idx_sync = {r.idx_sync[0], !INDEX_B};
      next_r.idx_prev = r.idx_sync[1];
      next_r.wvld = 1'b0;
      if (wr_stb && PADDR == FMTC_OFF_MODE) begin
         next_r.mode = wr_data;
      end
      if (rd_stb && PADDR == FMTC_OFF_STAT) begin
         next_r.irq = 1'b0;
      end
      case (r.state)
         FMTC_IDLE: begin
            if (data_wr) begin
               if (wr_data[4:0] == FMTC_OPC_FORMAT && wr_data[7] == 1'b0 && wr_data[5] == 1'b0) begin
                  next_r.dd = wr_data[FMTC_OPC_DD_BIT];
                  next_r.pcnt = 3'h0;
                  next_r.state = FMTC_PARAM;
               end else begin
                  next_r.st0 = FMTC_ST0_INVALID;
                  next_r.rcnt = 3'h0;
                  next_r.rlen = 3'h1;
                  next_r.state = FMTC_RESULT;
               end
            end
         end
         FMTC_PARAM: begin
            if (data_wr) begin
               next_r.pcnt = r.pcnt + 3'h1;
               case (r.pcnt)
                  3'h0: begin
                     next_r.side = wr_data[FMTC_ST_SIDE];
                     next_r.drive = wr_data[1:0];
                     next_r.bad_drive = (wr_data[1:0] == 2'h2 && !r.mode[FMTC_MODE_FOUR] &&
                        !r.mode[FMTC_MODE_SWAP]) || (wr_data[1:0] == 2'h3 &&
                        !r.mode[FMTC_MODE_FOUR]);
                  end
                  3'h1: next_r.size = wr_data[2:0];
                  3'h2: next_r.secs = wr_data;
                  3'h3: next_r.gap3 = wr_data;
                  default: next_r.fill = wr_data;
               endcase
               if (r.pcnt == FMTC_PARAM_CNT - 3'h1) begin
                  next_r.state = FMTC_WAIT_IDX;
               end
            end
         end
         FMTC_WAIT_IDX: begin
            if (r.bad_drive) begin
               next_r.st0 = {2'h1, 3'h0, r.side, r.drive};
               next_r.st1 = 8'h00;
               next_r.st2 = 8'h00;
               next_r.rcnt = 3'h0;
               next_r.rlen = FMTC_RES_CNT;
               next_r.irq = 1'b1;
               next_r.state = FMTC_RESULT;
            end else if (idx_edge) begin
               next_r.idxf = !r.mode[FMTC_MODE_IAF];
               next_r.secs_left = r.secs;
               next_r.idcnt = 2'h0;
               next_r.idreq = 1'b1;
               next_r.state = (r.secs == 8'h00) ? FMTC_FILL : FMTC_ID;
            end
         end
         FMTC_ID: begin
            if (data_wr) begin
               next_r.wbyte = wr_data;
               next_r.wvld = 1'b1;
               next_r.idxf = 1'b0;
               next_r.idcnt = r.idcnt + 2'h1;
               if (r.idcnt == FMTC_ID_CNT) begin
                  next_r.idreq = 1'b0;
                  next_r.state = FMTC_DATA;
               end
            end
         end
         FMTC_DATA: begin
            next_r.wbyte = r.fill;
            next_r.wvld = 1'b1;
            if (len_done) begin
               next_r.gap_left = r.gap3;
               next_r.state = FMTC_GAP;
            end
         end
         FMTC_GAP: begin
            next_r.wbyte = 8'h4e;
            next_r.wvld = (r.gap_left != 8'h00);
            if (r.gap_left != 8'h00) begin
               next_r.gap_left = r.gap_left - 8'h01;
            end else begin
               next_r.secs_left = r.secs_left - 8'h01;
               if (r.secs_left == 8'h01) begin
                  next_r.state = FMTC_FILL;
               end else begin
                  next_r.idreq = 1'b1;
                  next_r.state = FMTC_ID;
               end
            end
         end
         FMTC_FILL: begin
            next_r.wbyte = 8'h4e;
            next_r.wvld = 1'b1;
            if (idx_edge) begin
               next_r.st0 = {5'h00, r.side, r.drive};
               next_r.st1 = 8'h00;
               next_r.st2 = 8'h00;
               next_r.rcnt = 3'h0;
               next_r.rlen = FMTC_RES_CNT;
               next_r.irq = 1'b1;
               next_r.wvld = 1'b0;
               next_r.state = FMTC_RESULT;
            end
         end
         FMTC_RESULT: begin
            if (data_rd) begin
               next_r.rcnt = r.rcnt + 3'h1;
               if (r.rcnt == r.rlen - 3'h1) begin
                  next_r.state = FMTC_IDLE;
               end
            end
         end
         default: next_r.state = FMTC_IDLE;
      endcase
   end
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign HEAD_SIDE_OUTPUT_B = !r.side;
   assign DRIVE_SEL = r.drive;
   assign DOUBLE_DENSITY = r.dd;
   assign WR_GATE = (r.state == FMTC_ID) || (r.state == FMTC_DATA) ||
      (r.state == FMTC_GAP) || (r.state == FMTC_FILL);
   assign WR_BYTE = r.wbyte;
   assign WR_BYTE_VLD = r.wvld;
   assign INDEX_FIELD_WR = r.idxf;
   assign IRQ = r.irq;
endmodule
`default_nettype wire

// ===== tb/fmtc_checker.sv
// Assertion checker for the format track command block.
`timescale 1ns/100ps
`default_nettype none
module fmtc_checker (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic INDEX_B,
   input wire logic HEAD_SIDE_OUTPUT_B,
   input wire logic [1:0] DRIVE_SEL,
   input wire logic WR_GATE,
   input wire logic WR_BYTE_VLD,
   input wire logic IRQ
);
   logic [3:0] since_idx;
   wire dwr = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B)
         since_idx <= 4'hf;
      else if (!INDEX_B)
         since_idx <= 4'h0;
      else if (since_idx != 4'hf)
         since_idx <= since_idx + 4'h1;
   end
   default clocking ck @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   sequence acc_s;
      PSEL && PENABLE;
   endsequence
   sequence stat_rd_s;
      acc_s ##0 !PWRITE && PADDR == 12'h018;
   endsequence
   ready_now_a: assert property (acc_s |-> PREADY) else $error("pready missing");
   ready_idle_a: assert property (!PSEL |-> !PREADY) else $error("pready without select");
   bad_addr_a: assert property (acc_s ##0 PADDR > 12'h018 |-> PSLVERR)
      else $error("no error on unmapped access");
   good_addr_a: assert property (acc_s ##0 PADDR <= 12'h018 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
      else $error("error on mapped access");
   byte_gate_a: assert property (WR_BYTE_VLD |-> WR_GATE) else $error("byte outside gate");
   fmt_start_a: assert property ($rose(WR_GATE) |-> since_idx < 4'h8)
      else $error("format began away from index");
   fmt_end_a: assert property ($fell(WR_GATE) |-> since_idx < 4'h8 ##[0:2] IRQ)
      else $error("format end without index and irq");
   irq_clear_a: assert property (stat_rd_s |=> !IRQ) else $error("irq kept after read");
   side_src_a: assert property ($changed(HEAD_SIDE_OUTPUT_B) |-> $past(dwr) || $past(dwr, 2))
      else $error("side output moved alone");
   drive_src_a: assert property ($changed(DRIVE_SEL) |-> $past(dwr) || $past(dwr, 2))
      else $error("drive select moved alone");
endmodule
bind fmtc_top fmtc_checker chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .INDEX_B(INDEX_B), .HEAD_SIDE_OUTPUT_B(HEAD_SIDE_OUTPUT_B), .DRIVE_SEL(DRIVE_SEL),
   .WR_GATE(WR_GATE), .WR_BYTE_VLD(WR_BYTE_VLD), .IRQ(IRQ));
`default_nettype wire

// ===== tb/fmtc_drive_model.sv
// Drive model that makes index pulses and counts written fill bytes.
`timescale 1ns/100ps
`default_nettype none
module fmtc_drive_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clr,
   input wire logic [7:0] fill,
   input wire logic wr_gate,
   input wire logic [7:0] wr_byte,
   input wire logic wr_byte_vld,
   input wire logic index_field_wr,
   output logic index_b,
   output logic [15:0] n_fill,
   output logic seen_idxf
);
   logic [11:0] tick;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick <= 12'h0;
         index_b <= 1'b1;
         n_fill <= 16'h0;
         seen_idxf <= 1'b0;
      end else begin
         tick <= (tick == 12'hbb7) ? 12'h0 : tick + 12'h1;
         index_b <= tick < 12'hbb0;
         if (clr) begin
            n_fill <= 16'h0;
            seen_idxf <= 1'b0;
         end else begin
            if (wr_byte_vld && wr_gate && wr_byte == fill)
               n_fill <= n_fill + 16'h1;
            if (index_field_wr)
               seen_idxf <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/fmtc_top_tb.sv
// Self-checking testbench for the format track command block.
`timescale 1ns/100ps
`default_nettype none
module fmtc_top_tb;
   import fmtc_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [7:0] fill = 8'h0, wbyte;
   logic index_b, head_b, dd, gate, vld, idxf, irq, pready, pslverr, seen_idxf, err;
   logic [1:0] dsel;
   logic [15:0] n_fill;
   int errors = 0, n_compared = 0, cycles = 0;
   always #4 clk = !clk;
   fmtc_top uut (.SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr),
      .PRDATA(prdata), .INDEX_B(index_b), .HEAD_SIDE_OUTPUT_B(head_b), .DRIVE_SEL(dsel),
      .DOUBLE_DENSITY(dd), .WR_GATE(gate), .WR_BYTE(wbyte), .WR_BYTE_VLD(vld),
      .INDEX_FIELD_WR(idxf), .IRQ(irq));
   fmtc_drive_model drv (.clk(clk), .rst_b(rst_b), .clr(clr), .fill(fill), .wr_gate(gate),
      .wr_byte(wbyte), .wr_byte_vld(vld), .index_field_wr(idxf), .index_b(index_b),
      .n_fill(n_fill), .seen_idxf(seen_idxf));
   task automatic finish_test;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         finish_test;
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic fmt(input logic [7:0] mode, input logic [7:0] opc, input logic [39:0] prm);
      int i;
      int j;
      logic [7:0] ds;
      logic [7:0] sz;
      logic [31:0] id;
      ds = prm[39:32];
      sz = prm[31:24];
      apb(1'b1, FMTC_OFF_MODE, {24'h0, mode});
      rdchk(FMTC_OFF_MODE, {24'h0, mode});
      fill <= prm[7:0];
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      apb(1'b1, FMTC_OFF_DATA, {24'h0, opc});
      for (i = 4; i >= 0; i--)
         apb(1'b1, FMTC_OFF_DATA, {24'h0, prm[i*8+:8]});
      rdchk(FMTC_OFF_DOR, {30'h0, ds[1:0]});
      rdchk(FMTC_OFF_SRA, {28'h0, ds[2], 3'h0});
      rdchk(FMTC_OFF_ST3, {29'h0, ds[2:0]});
      check(32'(dsel), {30'h0, ds[1:0]});
      check(32'(!head_b), {31'h0, ds[2]});
      check(32'(dd), {31'h0, opc[6]});
      for (i = 0; i < int'(prm[23:16]); i++) begin
         id = {8'h07, 7'h0, ds[2], 8'(i + 1), sz};
         for (j = 3; j >= 0; j--) begin
            do apb(1'b0, FMTC_OFF_MSR, 32'h0); while (rd[7:0] !== 8'h90);
            apb(1'b1, FMTC_OFF_DATA, {24'h0, id[j*8+:8]});
         end
      end
      while (irq !== 1'b1)
         @(posedge clk);
      check(32'(n_fill), 32'(prm[23:16]) << (32'(sz) + 7));
      check(32'(seen_idxf), {31'h0, !mode[6]});
      rdchk(FMTC_OFF_MSR, 32'hd0);
      rdchk(FMTC_OFF_DATA, {29'h0, ds[2:0]});
      rdchk(FMTC_OFF_DATA, 32'h0);
      rdchk(FMTC_OFF_DATA, 32'h0);
      for (i = 0; i < 4; i++)
         apb(1'b0, FMTC_OFF_DATA, 32'h0);
      rdchk(FMTC_OFF_MSR, 32'h80);
      rdchk(FMTC_OFF_STAT, 32'h1);
      rdchk(FMTC_OFF_STAT, 32'h0);
      @(negedge clk);
      check(32'(irq), 32'h0);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rdchk(FMTC_OFF_MSR, 32'h80);
      rdchk(FMTC_OFF_MODE, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      $display("test 1 done");
      apb(1'b1, FMTC_OFF_DATA, 32'h12);
      rdchk(FMTC_OFF_MSR, 32'hd0);
      rdchk(FMTC_OFF_DATA, {24'h0, FMTC_ST0_INVALID});
      rdchk(FMTC_OFF_MSR, 32'h80);
      @(negedge clk);
      check(32'(irq), 32'h0);
      $display("test 2 done");
      fmt(8'h00, 8'h4d, {8'h05, 8'h00, 8'h02, 8'h6c, 8'ha5});
      $display("test 3 done");
      fmt(8'h43, 8'h0d, {8'h03, 8'h01, 8'h01, 8'h03, 8'h3c});
      $display("test 4 done");
      apb(1'b1, FMTC_OFF_MODE, 32'h0);
      apb(1'b1, FMTC_OFF_DATA, 32'h0d);
      apb(1'b1, FMTC_OFF_DATA, 32'h02);
      apb(1'b1, FMTC_OFF_DATA, 32'h00);
      apb(1'b1, FMTC_OFF_DATA, 32'h01);
      apb(1'b1, FMTC_OFF_DATA, 32'h10);
      apb(1'b1, FMTC_OFF_DATA, 32'h00);
      rdchk(FMTC_OFF_MSR, 32'hd0);
      rdchk(FMTC_OFF_DATA, 32'h42);
      for (int k = 0; k < 6; k++)
         apb(1'b0, FMTC_OFF_DATA, 32'h0);
      rdchk(FMTC_OFF_MSR, 32'h80);
      rdchk(FMTC_OFF_STAT, 32'h1);
      $display("test 5 done");
      finish_test;
   end
endmodule
`default_nettype wire
